//--- core/rdq_pkg.sv
// Shared constants for the receive descriptor-reference queue addressing block.
// Assumes a 32-bit register port with word-aligned byte offsets.
package rdq_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int IDX_W = 16;
  localparam int ADDR_W = 32;
  localparam int REG_AW = 12;
  localparam int DW_SHIFT = 2;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_BASE_LO = 12'h290;
  localparam logic [11:0] OFF_BASE_HI = 12'h294;
  localparam logic [11:0] OFF_LF_END = 12'h2a4;
  localparam logic [11:0] OFF_SF_START = 12'h2a8;
  localparam logic [11:0] OFF_SF_WRITE = 12'h2ac;
  localparam logic [11:0] OFF_SF_READ = 12'h2b0;
  localparam logic [11:0] OFF_SF_END = 12'h2b4;
  localparam logic [11:0] OFF_RDY_START = 12'h2b8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] IDX_RST = 16'h0000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;

  // ----------------------------------------
  // Address slots driven by the adders
  // ----------------------------------------
  typedef enum logic [2:0] {
    SLOT_SF_START,
    SLOT_SF_WRITE,
    SLOT_SF_READ,
    SLOT_SF_END,
    SLOT_LF_END,
    SLOT_RDY_START
  } rdq_slot_e;
  localparam int NUM_SLOTS = 6;

  // Index supplies bits 17 to 2 of the dword offset added to the base.
  function automatic logic [31:0] rdq_phys_addr(input logic [31:0] base, input logic [15:0] idx);
    rdq_phys_addr = base + {14'h0000, idx, 2'h0};
  endfunction

  // Circular advance: from the end index back to the start index.
  function automatic logic [15:0] rdq_next_idx(input logic [15:0] cur, input logic [15:0] first,
                                               input logic [15:0] last);
    rdq_next_idx = (cur == last) ? first : 16'(cur + 16'h0001);
  endfunction

endpackage

//--- core/rdq_addr_reg.sv
// One registered physical-address generator: base plus dword-scaled index.
// Assumes base and index come from flops on the same clock.
`timescale 1ns/10ps
module rdq_addr_reg (
  input wire logic i_clk,          // System clock.
  input wire logic i_rst,          // Asynchronous reset, active high.
  input wire logic [31:0] i_base,  // Effective queue base.
  input wire logic [15:0] i_idx,   // Queue index.
  output logic [31:0] o_addr       // Registered physical address.
);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_addr <= rdq_pkg::BASE_RST;
    end else begin
      o_addr <= rdq_pkg::rdq_phys_addr(i_base, i_idx);
    end
  end

endmodule

//--- core/rdq_queue_addr.sv
// Receive descriptor-reference queue addressing: index registers, queue base,
// circular pointer advance and physical address generation.
// Assumes a single-cycle register port and a DMA engine on the same clock.
//
// What this block does
// RQ1: Small free start address is start index shifted left two plus base.
// RQ2: Small free write address is write index shifted left two plus base.
// RQ3: Small free read address is read index shifted left two plus base.
// RQ4: Small free end address is end index shifted left two plus base.
// RQ5: Large free end address is its end index shifted left two plus base.
// RQ6: Ready start index is a writable 16-bit field, reset zero, upper half unused.
// RQ7: Ready start address is ready start index shifted left two plus base.
// RQ8: Host writes the queue base dword aligned, low two bits zero.
// RQ9: Low base half waits in a holding register until the high half is written.
// RQ10: Queue indices advance by one and wrap from end back to start.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module rdq_queue_addr #(
  parameter int IDX_W = rdq_pkg::IDX_W  // Index width; only the documented width is served.
) (
  input wire logic i_clk,                // System clock, 100 MHz.
  input wire logic i_rst,                // Asynchronous reset, active high.
  input wire logic [11:0] i_reg_addr,    // Register byte address.
  input wire logic [31:0] i_reg_wdata,   // Register write data.
  input wire logic i_reg_wr,             // Write strobe, one cycle.
  input wire logic i_reg_rd,             // Read strobe, one cycle.
  output logic [31:0] o_reg_rdata,       // Read data, valid the cycle after the strobe.
  input wire logic i_sf_write_adv,       // Pulse: a small free entry was written to host memory.
  input wire logic i_sf_read_adv,        // Pulse: a small free entry was taken from host memory.
  output logic [31:0] o_sf_start_addr,   // Small free queue start address.
  output logic [31:0] o_sf_write_addr,   // Small free queue write pointer address.
  output logic [31:0] o_sf_read_addr,    // Small free queue read pointer address.
  output logic [31:0] o_sf_end_addr,     // Small free queue end address.
  output logic [31:0] o_lf_end_addr,     // Large free queue end address.
  output logic [31:0] o_rdy_start_addr,  // Ready queue start address.
  output logic o_sf_empty                // Small free queue holds no entry.
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (IDX_W != 16) begin : g_bad_width
    $error("rdq_queue_addr: index width must be 16");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] small_free_start_index_q;
  logic [15:0] small_free_write_index_q;
  logic [15:0] small_free_read_index_q;
  logic [15:0] small_free_end_index_q;
  logic [15:0] large_free_end_index_q;
  logic [15:0] ready_start_index_q;
  logic [15:0] base_hold_q;
  logic [31:0] queue_base_q;
  logic [31:0] rdata_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic wr_sf_start;
  logic wr_sf_write;
  logic wr_sf_read;
  logic wr_sf_end;
  logic wr_lf_end;
  logic wr_rdy_start;
  logic wr_base_lo;
  logic wr_base_hi;
  assign wr_sf_start = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_SF_START);
  assign wr_sf_write = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_SF_WRITE);
  assign wr_sf_read = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_SF_READ);
  assign wr_sf_end = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_SF_END);
  assign wr_lf_end = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_LF_END);
  assign wr_rdy_start = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_RDY_START);
  assign wr_base_lo = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_BASE_LO);
  assign wr_base_hi = i_reg_wr && hit(i_reg_addr, rdq_pkg::OFF_BASE_HI);

  // ----------------------------------------
  // Static indices
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      small_free_start_index_q <= rdq_pkg::IDX_RST;
      small_free_end_index_q <= rdq_pkg::IDX_RST;
      large_free_end_index_q <= rdq_pkg::IDX_RST;
      ready_start_index_q <= rdq_pkg::IDX_RST;
    end else begin
      if (wr_sf_start) begin
        small_free_start_index_q <= i_reg_wdata[15:0];
      end
      if (wr_sf_end) begin
        small_free_end_index_q <= i_reg_wdata[15:0];
      end
      if (wr_lf_end) begin
        large_free_end_index_q <= i_reg_wdata[15:0];
      end
      if (wr_rdy_start) begin
        ready_start_index_q <= i_reg_wdata[15:0]; // RQ6
      end
    end
  end

  // ----------------------------------------
  // Circular pointers
  // ----------------------------------------
  // A software write in the same cycle as an advance wins, so that
  // re-initialising a queue is never undone by a stale advance.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      small_free_write_index_q <= rdq_pkg::IDX_RST;
    end else if (wr_sf_write) begin
      small_free_write_index_q <= i_reg_wdata[15:0];
    end else if (i_sf_write_adv) begin
      small_free_write_index_q <= rdq_pkg::rdq_next_idx(small_free_write_index_q,
                                    small_free_start_index_q, small_free_end_index_q); // RQ10
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      small_free_read_index_q <= rdq_pkg::IDX_RST;
    end else if (wr_sf_read) begin
      small_free_read_index_q <= i_reg_wdata[15:0];
    end else if (i_sf_read_adv) begin
      small_free_read_index_q <= rdq_pkg::rdq_next_idx(small_free_read_index_q,
                                   small_free_start_index_q, small_free_end_index_q); // RQ10
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sf_empty <= 1'b1;
    end else begin
      o_sf_empty <= (small_free_read_index_q == small_free_write_index_q);
    end
  end

  // ----------------------------------------
  // Queue base
  // ----------------------------------------
  // The base is only ever used whole; updating it on the high half avoids
  // addresses built from a half-old, half-new base. Bits 1:0 are stored as
  // written, alignment being the host's duty.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      base_hold_q <= rdq_pkg::BASE_RST[15:0];
      queue_base_q <= rdq_pkg::BASE_RST;
    end else begin
      if (wr_base_lo) begin
        base_hold_q <= i_reg_wdata[15:0]; // RQ9
      end
      if (wr_base_hi) begin
        queue_base_q <= {i_reg_wdata[15:0], base_hold_q}; // RQ9 RQ8
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(i_reg_addr, rdq_pkg::OFF_SF_START)) begin
      rdata_d[15:0] = small_free_start_index_q;
    end else if (hit(i_reg_addr, rdq_pkg::OFF_SF_WRITE)) begin
      rdata_d[15:0] = small_free_write_index_q;
    end else if (hit(i_reg_addr, rdq_pkg::OFF_SF_READ)) begin
      rdata_d[15:0] = small_free_read_index_q;
    end else if (hit(i_reg_addr, rdq_pkg::OFF_SF_END)) begin
      rdata_d[15:0] = small_free_end_index_q;
    end else if (hit(i_reg_addr, rdq_pkg::OFF_LF_END)) begin
      rdata_d[15:0] = large_free_end_index_q;
    end else if (hit(i_reg_addr, rdq_pkg::OFF_RDY_START)) begin
      rdata_d[15:0] = ready_start_index_q; // RQ6
    end else if (hit(i_reg_addr, rdq_pkg::OFF_BASE_LO)) begin
      rdata_d[15:0] = base_hold_q;
    end else if (hit(i_reg_addr, rdq_pkg::OFF_BASE_HI)) begin
      rdata_d[15:0] = queue_base_q[31:16];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Physical addresses
  // ----------------------------------------
  logic [15:0] slot_idx [rdq_pkg::NUM_SLOTS];
  logic [31:0] slot_addr [rdq_pkg::NUM_SLOTS];
  assign slot_idx[rdq_pkg::SLOT_SF_START] = small_free_start_index_q;
  assign slot_idx[rdq_pkg::SLOT_SF_WRITE] = small_free_write_index_q;
  assign slot_idx[rdq_pkg::SLOT_SF_READ] = small_free_read_index_q;
  assign slot_idx[rdq_pkg::SLOT_SF_END] = small_free_end_index_q;
  assign slot_idx[rdq_pkg::SLOT_LF_END] = large_free_end_index_q;
  assign slot_idx[rdq_pkg::SLOT_RDY_START] = ready_start_index_q;

  for (genvar g = 0; g < rdq_pkg::NUM_SLOTS; g++) begin : g_addr
    rdq_addr_reg u_addr (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_base(queue_base_q),
      .i_idx(slot_idx[g]),
      .o_addr(slot_addr[g])
    ); // RQ1 RQ2 RQ3 RQ4 RQ5 RQ7
  end

  assign o_sf_start_addr = slot_addr[rdq_pkg::SLOT_SF_START]; // RQ1
  assign o_sf_write_addr = slot_addr[rdq_pkg::SLOT_SF_WRITE]; // RQ2
  assign o_sf_read_addr = slot_addr[rdq_pkg::SLOT_SF_READ]; // RQ3
  assign o_sf_end_addr = slot_addr[rdq_pkg::SLOT_SF_END]; // RQ4
  assign o_lf_end_addr = slot_addr[rdq_pkg::SLOT_LF_END]; // RQ5
  assign o_rdy_start_addr = slot_addr[rdq_pkg::SLOT_RDY_START]; // RQ7

endmodule

//--- verif/rdq_dma_side.sv
// Model of the DMA side that posts and takes small free queue entries.
// Assumes one-cycle requests from the bench on the same clock.
`timescale 1ns/10ps
module rdq_dma_side (
  input wire logic i_clk, // Clock.
  input wire logic i_rst, // Reset, active high.
  input wire logic i_post, // Post one entry.
  input wire logic i_take, // Take one entry.
  output logic o_write_adv, // Write index advance pulse.
  output logic o_read_adv // Read index advance pulse.
);
  // Pulses leave one cycle after the request, as a memory round trip would.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_write_adv <= 1'b0;
      o_read_adv <= 1'b0;
    end else begin
      o_write_adv <= i_post;
      o_read_adv <= i_take;
    end
  end
endmodule

//--- verif/rdq_queue_addr_checker.sv
// Concurrent checks on the queue addressing block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module rdq_queue_addr_checker (
  input wire logic i_clk, // Clock.
  input wire logic i_rst, // Reset.
  input wire logic [11:0] i_reg_addr, // Address.
  input wire logic [31:0] i_reg_wdata, // Write data.
  input wire logic i_reg_wr, // Write strobe.
  input wire logic i_reg_rd, // Read strobe.
  input wire logic [31:0] o_reg_rdata, // Read data.
  input wire logic i_sf_write_adv, // Write advance.
  input wire logic i_sf_read_adv, // Read advance.
  input wire logic [31:0] o_sf_start_addr, // Start.
  input wire logic [31:0] o_sf_write_addr, // Write.
  input wire logic [31:0] o_sf_read_addr, // Read.
  input wire logic [31:0] o_sf_end_addr, // End.
  input wire logic [31:0] o_lf_end_addr, // Large end.
  input wire logic [31:0] o_rdy_start_addr, // Ready start.
  input wire logic o_sf_empty // Empty.
);
  logic [15:0] hold_q;
  logic [31:0] base_q;
  // The effective base is mirrored so that address checks can name their figure.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_q <= 16'h0000;
      base_q <= 32'h0000_0000;
    end else if (i_reg_wr && i_reg_addr == rdq_pkg::OFF_BASE_LO) begin
      hold_q <= i_reg_wdata[15:0];
    end else if (i_reg_wr && i_reg_addr == rdq_pkg::OFF_BASE_HI) begin
      base_q <= {i_reg_wdata[15:0], hold_q};
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_quiet;
    !i_reg_wr && !i_sf_write_adv && !i_sf_read_adv;
  endsequence
  // The written index is recovered two samples back, which keeps the property free of local variables.
  property p_idx(logic [11:0] off, logic [31:0] addr);
    (i_reg_wr && i_reg_addr == off) ##1 s_quiet |-> ##1 addr == base_q + {14'h0, $past(i_reg_wdata[15:0], 2), 2'h0};
  endproperty
  a_sf_start: assert property (p_idx(rdq_pkg::OFF_SF_START, o_sf_start_addr))
    else $error("Start address wrong.");
  a_sf_write: assert property (p_idx(rdq_pkg::OFF_SF_WRITE, o_sf_write_addr))
    else $error("Write address wrong.");
  a_sf_read: assert property (p_idx(rdq_pkg::OFF_SF_READ, o_sf_read_addr))
    else $error("Read address wrong.");
  a_sf_end: assert property (p_idx(rdq_pkg::OFF_SF_END, o_sf_end_addr))
    else $error("End address wrong.");
  a_lf_end: assert property (p_idx(rdq_pkg::OFF_LF_END, o_lf_end_addr))
    else $error("Large end address wrong.");
  a_rdy_start: assert property (p_idx(rdq_pkg::OFF_RDY_START, o_rdy_start_addr))
    else $error("Ready start address wrong.");
  a_rdy_upper: assert property (i_reg_rd && i_reg_addr == rdq_pkg::OFF_RDY_START |=> o_reg_rdata[31:16] == 16'h0)
    else $error("Upper half not zero.");
  a_base_hold: assert property (s_quiet ##1 (i_reg_wr && i_reg_addr == rdq_pkg::OFF_BASE_LO) ##1 s_quiet
    |=> $stable(o_sf_start_addr) && $stable(o_rdy_start_addr)) else $error("Low base write moved an address.");
  a_read_wrap: assert property (s_quiet [*2] ##1 (i_sf_read_adv && !i_reg_wr && o_sf_read_addr == o_sf_end_addr)
    |-> ##2 o_sf_read_addr == o_sf_start_addr) else $error("Read index did not wrap.");
  a_write_step: assert property (s_quiet [*2] ##1 (i_sf_write_adv && !i_reg_wr && o_sf_write_addr != o_sf_end_addr)
    |-> ##2 o_sf_write_addr == $past(o_sf_write_addr, 2) + 32'h4) else $error("Write index did not step.");
  // Flag and addresses lag the indices by the same one cycle, so they must always agree.
  a_empty_match: assert property (o_sf_empty == (o_sf_read_addr == o_sf_write_addr))
    else $error("Empty flag disagrees with pointer addresses.");
endmodule

//--- verif/tb_rdq_queue_addr.sv
// Self-checking bench for the queue addressing block.
// Assumes the package, design, checker and DMA model are compiled first.
`timescale 1ns/10ps
module tb_rdq_queue_addr;
  typedef struct {logic [11:0] off; logic [15:0] val;} rdq_row_s;
  logic i_clk, i_rst, i_reg_wr, i_reg_rd, post, take, i_sf_write_adv, i_sf_read_adv, o_sf_empty;
  logic [11:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, o_sf_start_addr, o_sf_write_addr, o_sf_read_addr;
  logic [31:0] o_sf_end_addr, o_lf_end_addr, o_rdy_start_addr, base, q;
  int fails, n_compared, cyc;
  rdq_row_s rows [6];
  rdq_queue_addr rdq_queue_addr_i (.i_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_sf_write_adv, .i_sf_read_adv, .o_sf_start_addr, .o_sf_write_addr, .o_sf_read_addr, .o_sf_end_addr,
    .o_lf_end_addr, .o_rdy_start_addr, .o_sf_empty);
  rdq_dma_side rdq_dma_side_i (.i_clk, .i_rst, .i_post(post), .i_take(take), .o_write_adv(i_sf_write_adv),
    .o_read_adv(i_sf_read_adv));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 q = o_reg_rdata;
  endtask
  task automatic adv(input logic w);
    @(posedge i_clk);
    post <= w;
    take <= !w;
    @(posedge i_clk);
    post <= 1'b0;
    take <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  function automatic logic [31:0] sel(input logic [11:0] off);
    case (off)
      rdq_pkg::OFF_SF_START: sel = o_sf_start_addr;
      rdq_pkg::OFF_SF_WRITE: sel = o_sf_write_addr;
      rdq_pkg::OFF_SF_READ: sel = o_sf_read_addr;
      rdq_pkg::OFF_SF_END: sel = o_sf_end_addr;
      rdq_pkg::OFF_LF_END: sel = o_lf_end_addr;
      default: sel = o_rdy_start_addr;
    endcase
  endfunction
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A hang is cut short well beyond the hundred or so cycles the tests need.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    rows = '{'{rdq_pkg::OFF_SF_START, 16'h0010}, '{rdq_pkg::OFF_SF_END, 16'h0013}, '{rdq_pkg::OFF_SF_WRITE, 16'h0011},
      '{rdq_pkg::OFF_SF_READ, 16'h0013}, '{rdq_pkg::OFF_LF_END, 16'hffff}, '{rdq_pkg::OFF_RDY_START, 16'h8001}};
    i_rst = 1'b1;
    {i_reg_wr, i_reg_rd, post, take, i_reg_addr, i_reg_wdata} = '0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk(o_sf_start_addr, 32'h0);
    chk({31'h0, o_sf_empty}, 32'h1);
    rd(rdq_pkg::OFF_RDY_START);
    chk(q, 32'h0);
    $display("Reset test done.");
    wr(rdq_pkg::OFF_BASE_LO, 32'h0000_2340);
    wr(rdq_pkg::OFF_BASE_HI, 32'h0000_8000);
    base = 32'h8000_2340;
    foreach (rows[i]) begin
      wr(rows[i].off, {16'hffff, rows[i].val});
      repeat (2) @(posedge i_clk);
      #1 chk(sel(rows[i].off), base + {14'h0, rows[i].val, 2'h0});
      rd(rows[i].off);
      chk(q, {16'h0, rows[i].val});
    end
    rd(12'h2bc);
    chk(q, 32'h0);
    $display("Index table done.");
    wr(rdq_pkg::OFF_BASE_LO, 32'h0000_1000);
    repeat (3) @(posedge i_clk);
    #1 chk(o_sf_start_addr, 32'h8000_2380);
    wr(rdq_pkg::OFF_BASE_HI, 32'h0000_4000);
    base = 32'h4000_1000;
    repeat (2) @(posedge i_clk);
    #1 chk(o_rdy_start_addr, base + 32'h0002_0004);
    $display("Base hold test done.");
    adv(1'b0);
    chk(o_sf_read_addr, base + 32'h40);
    adv(1'b0);
    chk(o_sf_read_addr, base + 32'h44);
    chk({31'h0, o_sf_empty}, 32'h1);
    adv(1'b1);
    chk(o_sf_write_addr, base + 32'h48);
    chk({31'h0, o_sf_empty}, 32'h0);
    adv(1'b1);
    chk(o_sf_write_addr, base + 32'h4c);
    adv(1'b1);
    chk(o_sf_write_addr, base + 32'h40);
    $display("Circular advance test done.");
    // A software write and a read advance meet at one edge; the write must win.
    fork
      adv(1'b0);
      begin
        @(posedge i_clk);
        wr(rdq_pkg::OFF_SF_READ, 32'h0000_0010);
      end
    join
    chk(o_sf_read_addr, base + 32'h40);
    chk({31'h0, o_sf_empty}, 32'h1);
    rd(rdq_pkg::OFF_BASE_HI);
    chk(q, 32'h0000_4000);
    rd(rdq_pkg::OFF_BASE_LO);
    chk(q, 32'h0000_1000);
    $display("Write priority test done.");
    @(posedge i_clk);
    i_rst <= 1'b1;
    #1 chk(o_sf_read_addr, 32'h0);
    chk({31'h0, o_sf_empty}, 32'h1);
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk(o_lf_end_addr, 32'h0);
    rd(rdq_pkg::OFF_RDY_START);
    chk(q, 32'h0);
    $display("Mid-run reset test done.");
    wrap_up();
  end
endmodule
bind rdq_queue_addr rdq_queue_addr_checker rdq_queue_addr_checker_i (.i_clk, .i_rst, .i_reg_addr, .i_reg_wdata,
  .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_sf_write_adv, .i_sf_read_adv, .o_sf_start_addr, .o_sf_write_addr,
  .o_sf_read_addr, .o_sf_end_addr, .o_lf_end_addr, .o_rdy_start_addr, .o_sf_empty);
